// File: core/dfl_pkg.sv
// constants for the diagnostic fault latch bank
package dfl_pkg;
    localparam int DFL_AW = 8;
    localparam int DFL_DW = 8;
    localparam logic [7:0] DFL_OFS_SUMMARY = 8'h35;
    localparam logic [7:0] DFL_OFS_IN_CH1 = 8'h36;
    localparam logic [7:0] DFL_OFS_IN_CH2 = 8'h37;
    localparam logic [7:0] DFL_OFS_OUT_CH1 = 8'h38;
    localparam logic [7:0] DFL_OFS_OUT_CH2 = 8'h39;
    localparam logic [7:0] DFL_OFS_MISC = 8'h3A;
    localparam logic [7:0] DFL_RST_REG = 8'h00;
    localparam logic [7:0] DFL_UNMAPPED_DATA = 8'h00;
    // field positions
    localparam int DFL_SUM_IN1_BIT = 7;
    localparam int DFL_SUM_IN2_BIT = 6;
    localparam int DFL_SUM_OUT1_BIT = 5;
    localparam int DFL_SUM_OUT2_BIT = 4;
    localparam int DFL_SUM_VBAT_BIT = 3;
    localparam int DFL_OUT_FLAG_LSB = 4;
    localparam int DFL_CONV1_MASK_BIT = 3;
    localparam int DFL_CONV2_MASK_BIT = 2;
    localparam int DFL_REG_MASK_BIT = 1;
    localparam int DFL_REG_FLAG_BIT = 0;
    localparam int DFL_OV_LSB = 4;
    localparam int DFL_HS_LSB = 1;
    localparam int DFL_BUDGET_BIT = 0;
    // raw fault vector layout
    localparam int DFL_RAW_W = 34;
    localparam int DFL_RAW_IN1 = 0;
    localparam int DFL_RAW_IN2 = 8;
    localparam int DFL_RAW_OUT1 = 16;
    localparam int DFL_RAW_OUT2 = 20;
    localparam int DFL_RAW_VBAT = 24;
    localparam int DFL_RAW_REG = 25;
    localparam int DFL_RAW_OV = 26;
    localparam int DFL_RAW_HS = 30;
    localparam int DFL_RAW_BUDGET = 33;
    localparam logic [33:0] DFL_RST_RAW = 34'h0;
endpackage

// File: core/dfl_bank.sv
// latched diagnostic fault flag register bank
`timescale 1ns/1ps
module dfl_bank
    import dfl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control register port
    input wire logic [DFL_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DFL_DW-1:0] reg_wdata,
    output logic [DFL_DW-1:0] reg_rdata,
    // fault detector levels, asynchronous to clk_sys
    input wire logic [7:0] in_ch1_fault,
    input wire logic [7:0] in_ch2_fault,
    input wire logic [3:0] out_ch1_fault,
    input wire logic [3:0] out_ch2_fault,
    input wire logic vbat_short_fault,
    input wire logic regulator_short_fault,
    input wire logic [3:0] overvoltage_fault,
    input wire logic [2:0] headset_event,
    input wire logic processor_budget_overload,
    // live view and masks
    output logic [7:0] live_summary,
    output logic conv1_overload_mask,
    output logic conv2_overload_mask,
    output logic regulator_short_mask
);

    typedef struct packed {
        logic [DFL_RAW_W-1:0] sync1;
        logic [DFL_RAW_W-1:0] sync2;
        logic [7:0] in1;
        logic [7:0] in2;
        logic [3:0] out1;
        logic [3:0] out2;
        logic vbat;
        logic reg_sc;
        logic [3:0] ov;
        logic [2:0] hs;
        logic budget;
        logic conv1_mask;
        logic conv2_mask;
        logic reg_mask;
        logic [7:0] rdata;
        logic [7:0] live;
    } dfl_state_t;

    dfl_state_t st;
    dfl_state_t next_st;

    logic [DFL_RAW_W-1:0] raw;
    assign raw = {processor_budget_overload, headset_event,
                  overvoltage_fault, regulator_short_fault,
                  vbat_short_fault, out_ch2_fault, out_ch1_fault,
                  in_ch2_fault, in_ch1_fault};

    // synchronised fault levels
    logic [7:0] f_in1;
    logic [7:0] f_in2;
    logic [3:0] f_out1;
    logic [3:0] f_out2;
    logic f_vbat;
    logic f_reg;
    logic [3:0] f_ov;
    logic [2:0] f_hs;
    logic f_budget;
    assign f_in1 = st.sync2[DFL_RAW_IN1 +: 8];
    assign f_in2 = st.sync2[DFL_RAW_IN2 +: 8];
    assign f_out1 = st.sync2[DFL_RAW_OUT1 +: 4];
    assign f_out2 = st.sync2[DFL_RAW_OUT2 +: 4];
    assign f_vbat = st.sync2[DFL_RAW_VBAT];
    assign f_reg = st.sync2[DFL_RAW_REG];
    assign f_ov = st.sync2[DFL_RAW_OV +: 4];
    assign f_hs = st.sync2[DFL_RAW_HS +: 3];
    assign f_budget = st.sync2[DFL_RAW_BUDGET];

    // current register images
    logic [7:0] img_sum;
    logic [7:0] img_in1;
    logic [7:0] img_in2;
    logic [7:0] img_out1;
    logic [7:0] img_out2;
    logic [7:0] img_misc;

    always_comb begin
        img_sum = DFL_RST_REG;
        img_sum[DFL_SUM_IN1_BIT] = |st.in1;
        img_sum[DFL_SUM_IN2_BIT] = |st.in2;
        img_sum[DFL_SUM_OUT1_BIT] = |st.out1;
        img_sum[DFL_SUM_OUT2_BIT] = |st.out2;
        img_sum[DFL_SUM_VBAT_BIT] = st.vbat;
        img_in1 = st.in1;
        img_in2 = st.in2;
        img_out1 = DFL_RST_REG;
        img_out1[DFL_OUT_FLAG_LSB +: 4] = st.out1;
        img_out1[DFL_CONV1_MASK_BIT] = st.conv1_mask;
        img_out1[DFL_CONV2_MASK_BIT] = st.conv2_mask;
        img_out2 = DFL_RST_REG;
        img_out2[DFL_OUT_FLAG_LSB +: 4] = st.out2;
        img_out2[DFL_REG_MASK_BIT] = st.reg_mask;
        img_out2[DFL_REG_FLAG_BIT] = st.reg_sc;
        img_misc = DFL_RST_REG;
        img_misc[DFL_OV_LSB +: 4] = st.ov;
        img_misc[DFL_HS_LSB +: 3] = st.hs;
        img_misc[DFL_BUDGET_BIT] = st.budget;
    end

    // read strobes per register
    logic rd_sum;
    logic rd_in1;
    logic rd_in2;
    logic rd_out1;
    logic rd_out2;
    logic rd_misc;
    assign rd_sum = reg_rd && (reg_addr == DFL_OFS_SUMMARY);
    assign rd_in1 = reg_rd && (reg_addr == DFL_OFS_IN_CH1);
    assign rd_in2 = reg_rd && (reg_addr == DFL_OFS_IN_CH2);
    assign rd_out1 = reg_rd && (reg_addr == DFL_OFS_OUT_CH1);
    assign rd_out2 = reg_rd && (reg_addr == DFL_OFS_OUT_CH2);
    assign rd_misc = reg_rd && (reg_addr == DFL_OFS_MISC);

    always_comb begin
        next_st = st;
        next_st.sync1 = raw;
        next_st.sync2 = st.sync1;
        // flags keep until read; a present fault always wins
        next_st.in1 = f_in1 | (rd_in1 ? 8'h00 : st.in1);
        next_st.in2 = f_in2 | (rd_in2 ? 8'h00 : st.in2);
        next_st.out1 = f_out1 | (rd_out1 ? 4'h0 : st.out1);
        next_st.out2 = f_out2 | (rd_out2 ? 4'h0 : st.out2);
        next_st.vbat = f_vbat | (~rd_sum & st.vbat);
        next_st.reg_sc = f_reg | (~rd_out2 & st.reg_sc);
        next_st.ov = f_ov | (rd_misc ? 4'h0 : st.ov);
        next_st.hs = f_hs | (rd_misc ? 3'h0 : st.hs);
        next_st.budget = f_budget | (~rd_misc & st.budget);
        // only mask bits take writes; flags and reserved bits ignore them
        if (reg_wr && (reg_addr == DFL_OFS_OUT_CH1)) begin
            next_st.conv1_mask = reg_wdata[DFL_CONV1_MASK_BIT];
            next_st.conv2_mask = reg_wdata[DFL_CONV2_MASK_BIT];
        end
        if (reg_wr && (reg_addr == DFL_OFS_OUT_CH2)) begin
            next_st.reg_mask = reg_wdata[DFL_REG_MASK_BIT];
        end
        if (reg_rd) begin
            case (reg_addr)
                DFL_OFS_SUMMARY: next_st.rdata = img_sum;
                DFL_OFS_IN_CH1: next_st.rdata = img_in1;
                DFL_OFS_IN_CH2: next_st.rdata = img_in2;
                DFL_OFS_OUT_CH1: next_st.rdata = img_out1;
                DFL_OFS_OUT_CH2: next_st.rdata = img_out2;
                DFL_OFS_MISC: next_st.rdata = img_misc;
                default: next_st.rdata = DFL_UNMAPPED_DATA;
            endcase
        end
        // live summary follows present faults without holding
        next_st.live = DFL_RST_REG;
        next_st.live[DFL_SUM_IN1_BIT] = |f_in1;
        next_st.live[DFL_SUM_IN2_BIT] = |f_in2;
        next_st.live[DFL_SUM_OUT1_BIT] = |f_out1;
        next_st.live[DFL_SUM_OUT2_BIT] = |f_out2;
        next_st.live[DFL_SUM_VBAT_BIT] = f_vbat;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st.sync1 <= DFL_RST_RAW;
            st.sync2 <= DFL_RST_RAW;
            st.in1 <= DFL_RST_REG;
            st.in2 <= DFL_RST_REG;
            st.out1 <= 4'h0;
            st.out2 <= 4'h0;
            st.vbat <= 1'b0;
            st.reg_sc <= 1'b0;
            st.ov <= 4'h0;
            st.hs <= 3'h0;
            st.budget <= 1'b0;
            st.conv1_mask <= 1'b0;
            st.conv2_mask <= 1'b0;
            st.reg_mask <= 1'b0;
            st.rdata <= DFL_RST_REG;
            st.live <= DFL_RST_REG;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign live_summary = st.live;
    assign conv1_overload_mask = st.conv1_mask;
    assign conv2_overload_mask = st.conv2_mask;
    assign regulator_short_mask = st.reg_mask;

endmodule

// File: verification/dfl_checker.sv
// assertions on the fault latch bank ports
`timescale 1ns/1ps
module dfl_checker
    import dfl_pkg::*;
(
    // clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [DFL_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DFL_DW-1:0] reg_wdata,
    input wire logic [DFL_DW-1:0] reg_rdata,
    // faults, live view and masks
    input wire logic [7:0] in_ch1_fault,
    input wire logic [7:0] live_summary,
    input wire logic conv1_overload_mask,
    input wire logic conv2_overload_mask,
    input wire logic regulator_short_mask
);
    wire [1:0] msk = {conv1_overload_mask, conv2_overload_mask};
    wire wr38 = reg_wr && reg_addr == DFL_OFS_OUT_CH1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_on; (in_ch1_fault != 8'h00) [*3]; endsequence
    sequence s_off; (in_ch1_fault == 8'h00) [*3]; endsequence
    live_on_a:
        assert property (s_on |=> live_summary[7]) else $error("live on");
    live_off_a:
        assert property (s_off |=> !live_summary[7]) else $error("live off");
    live_rsvd_a:
        assert property (live_summary[2:0] == 3'h0) else $error("live rsvd");
    mask_wr_a:
        assert property (wr38 |=> msk == $past(reg_wdata[3:2]))
        else $error("mask write");
    mask_hold_a:
        assert property (!wr38 |=> $stable(msk)) else $error("mask hold");
    reg_mask_a:
        assert property (reg_wr && reg_addr == DFL_OFS_OUT_CH2 |=>
            regulator_short_mask == $past(reg_wdata[1])) else $error("rmask");
    rd_hold_a:
        assert property (!reg_rd |=> $stable(reg_rdata)) else $error("hold");
    unmapped_a:
        assert property (reg_rd && (reg_addr < DFL_OFS_SUMMARY ||
            reg_addr > DFL_OFS_MISC) |=> reg_rdata == DFL_UNMAPPED_DATA)
        else $error("unmapped");
    out1_rd_a:
        assert property (reg_rd && !reg_wr && reg_addr == DFL_OFS_OUT_CH1 |=>
            reg_rdata[3:0] == {$past(msk), 2'b00}) else $error("out1 read");
endmodule
bind dfl_bank dfl_checker i_chk (.clk_sys, .rst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .in_ch1_fault, .live_summary,
    .conv1_overload_mask, .conv2_overload_mask, .regulator_short_mask);

// File: verification/diag_fault_latch_bank_tb.sv
// self-checking bench for the fault latch bank
`timescale 1ns/1ps
module diag_fault_latch_bank_tb;
    import dfl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] live_summary;
    logic [33:0] f = 34'h0;
    logic m1, m2, mr;
    int n_errors = 0;
    int checked = 0;
    // fault pattern, register hit, its image, summary image
    logic [33:0] tv [6] = '{34'hA5, 34'h5A00, 34'h9_0000, 34'h260_0000,
        34'h100_0000, 34'h3_6800_0000};
    logic [7:0] ta [6] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h35, 8'h3A};
    logic [7:0] te [6] = '{8'hA5, 8'h5A, 8'h90, 8'h61, 8'h00, 8'hAB};
    logic [7:0] ts [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h00};
    dfl_bank i_dut (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .in_ch1_fault(f[7:0]),
        .in_ch2_fault(f[15:8]), .out_ch1_fault(f[19:16]),
        .out_ch2_fault(f[23:20]), .vbat_short_fault(f[24]),
        .regulator_short_fault(f[25]), .overvoltage_fault(f[29:26]),
        .headset_event(f[32:30]), .processor_budget_overload(f[33]),
        .live_summary, .conv1_overload_mask(m1),
        .conv2_overload_mask(m2), .regulator_short_mask(mr));
    task automatic chk(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one register access, then an idle cycle
    task automatic acc(input logic w, input logic [7:0] a, d, e);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        wt(1);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        if (!w) chk($sformatf("reg_%h", a), e, reg_rdata);
        wt(1);
    endtask
    task automatic final_report;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_reset;
        for (int a = 8'h34; a < 8'h3C; a++) begin
            acc(1'b0, 8'(a), 8'h00, 8'h00);
        end
        $display("reset values done");
    endtask
    task automatic t_faults;
        for (int i = 0; i < 6; i++) begin
            f = tv[i];
            wt(4);
            chk("live", ts[i], live_summary);
            f = 34'h0;
            wt(4);
            chk("live", 8'h00, live_summary);
            acc(1'b0, 8'h35, 8'h00, ts[i]);
            acc(1'b0, ta[i], 8'h00, te[i]);
            acc(1'b0, ta[i], 8'h00, 8'h00);
            acc(1'b0, 8'h35, 8'h00, 8'h00);
        end
        f = 34'h1;
        wt(4);
        acc(1'b0, 8'h36, 8'h00, 8'h01);
        f = 34'h0;
        wt(4);
        acc(1'b0, 8'h36, 8'h00, 8'h01);
        acc(1'b0, 8'h36, 8'h00, 8'h00);
        $display("fault latching done");
    endtask
    task automatic t_masks;
        acc(1'b1, 8'h38, 8'h0C, 8'h00);
        acc(1'b1, 8'h39, 8'h02, 8'h00);
        chk("masks", 8'h07, {5'h00, m1, m2, mr});
        acc(1'b0, 8'h38, 8'h00, 8'h0C);
        acc(1'b0, 8'h39, 8'h00, 8'h02);
        acc(1'b1, 8'h3A, 8'hFF, 8'h00);
        acc(1'b0, 8'h3A, 8'h00, 8'h00);
        acc(1'b1, 8'h38, 8'h00, 8'h00);
        acc(1'b1, 8'h39, 8'h00, 8'h00);
        chk("masks", 8'h00, {5'h00, m1, m2, mr});
        $display("mask bits done");
    endtask
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        wt(1);
        t_reset();
        t_faults();
        t_masks();
        final_report();
    end
endmodule
